//--- inc/cch_pkg.sv
/*
 * shared constants for the cam controller program-select and encoder link.
 * assumes one 10 MHz system clock at both ends.
 */
package cch_pkg;
    // ************************************************************
    // clock and timing
    // ************************************************************
    localparam int CLK_HZ = 10_000_000;
    localparam int STROBE_MIN_MS = 150;
    localparam int CHANGE_MS = 1000;
    localparam int DEBOUNCE_US = 1000;
    localparam int STROBE_HOLD_MS = 200;
    localparam int STROBE_MIN_CYC = STROBE_MIN_MS * (CLK_HZ / 1000);
    localparam int CHANGE_CYC = CHANGE_MS * (CLK_HZ / 1000);
    localparam int DEBOUNCE_CYC = DEBOUNCE_US * (CLK_HZ / 1_000_000);
    localparam int STROBE_HOLD_CYC = STROBE_HOLD_MS * (CLK_HZ / 1000);
    localparam int CNT_W = 24;

    // ************************************************************
    // link widths and codes
    // ************************************************************
    localparam int PROG_W = 5;
    localparam int PNUM_W = 6;
    localparam logic [PNUM_W-1:0] PROG_ALL_LOW = 6'h20;
    localparam logic [PNUM_W-1:0] PROG_RESET = 6'h01;
    localparam int PROG_MAX = 32;
    localparam int ECHO_W = 8;
    localparam int ENC_MAX = 15;
    localparam int ENC_PIN_W = 16;
    localparam int SEL_W = 3;
    localparam int ENC_IDX_W = 2;
    localparam logic [SEL_W-1:0] SEL_FIRST_N = 3'h6;
    localparam logic [SEL_W-1:0] SEL_NONE_N = 3'h7;

    // ************************************************************
    // controller register map (word aligned)
    // ************************************************************
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_ENC = 8'h04;
    localparam logic [7:0] REG_STAT = 8'h08;
    localparam int CTRL_PROG_LSB = 0;
    localparam int CTRL_STROBE_BIT = 5;
    localparam int CTRL_KEYPAD_BIT = 6;
    localparam int CTRL_UP_BIT = 7;
    localparam int STAT_ECHO_LSB = 0;
    localparam int STAT_READY_BIT = 8;
    localparam int STAT_STORE_BIT = 9;
    localparam int STAT_RELEASE_BIT = 10;
    localparam int STAT_SETUP_BIT = 11;
    localparam int STAT_PARITY_BIT = 12;
    localparam int STAT_LSB_BIT = 13;
    localparam int STAT_DIR_BIT = 14;
    localparam int STAT_SEL_LSB = 15;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HRESP_OKAY = 2'h0;

    // ************************************************************
    // program change sequencer
    // ************************************************************
    typedef enum logic [1:0] {
        CCH_IDLE = 2'b00,
        CCH_QUAL = 2'b01,
        CCH_CHANGE = 2'b10
    } cch_pstate_t;
endpackage

//--- inc/cch_link_if.sv
/*
 * pin-level link between the cam controller and the machine controller
 * plus encoder side. all pins are plain levels sampled on the common clock.
 */
`timescale 1ns/1ps
interface cch_link_if #(parameter int N_OUT = 24);
    import cch_pkg::*;
    // controller to device
    logic [PROG_W-1:0] prog_sel;
    logic strobe;
    logic kp_enable;
    logic [ENC_PIN_W-1:0] enc_data;
    logic enc_up;
    // device to controller
    logic [N_OUT-1:0] cam_out;
    logic program_parity_out;
    logic encoder_lsb_echo;
    logic ready;
    logic store;
    logic release_ok;
    logic setup;
    logic [SEL_W-1:0] enc_sel_n;
    logic dir_fwd;

    modport dev (
        input prog_sel, strobe, kp_enable, enc_data, enc_up,
        output cam_out, program_parity_out, encoder_lsb_echo, ready, store,
        output release_ok, setup, enc_sel_n, dir_fwd
    );
    modport ctl (
        output prog_sel, strobe, kp_enable, enc_data, enc_up,
        input cam_out, program_parity_out, encoder_lsb_echo, ready, store,
        input release_ok, setup, enc_sel_n, dir_fwd
    );
endinterface

//--- logic/cch_dev.sv
/*
 * cam controller i/o face: program select with strobe qualification,
 * status outputs, program echo with odd parity, parallel encoder port.
 * assumes the core supplies mode, speed, error and cam levels on its
 * user ports, all synchronous to i_mclk.
 */
`timescale 1ns/1ps
// Contract
// - echo mode puts program on last eight outputs
// - echo group is top eight outputs
// - parity output makes echo odd parity
// - encoder lsb copied out, encoder 1 on three
// - controller presents binary program, all-low is 32
// - load on strobe rise held 150 ms
// - one second change, cams held, ready low
// - accept only slow and nothing unsaved
// - release high in run at low speed
// - keypad enabled only by enable input
// - ready low on error, programming, copy
// - store high while data unsaved
// - setup high in on-line mode
// - up to 15 encoder bits, upper ignored
// - parity sits just above top encoder bit
// - up-down input high means counting up
// - one active-low select per encoder
// - expander decodes all from first select
// - direction output high means forwards
// - controller ties unused inputs low
module cch_dev
    import cch_pkg::*;
#(
    parameter int N_OUT = 24,
    parameter int N_PROG = 32,
    parameter int ENC_BITS = 15,
    parameter int N_ENC = 1,
    parameter bit USE_EXPANDER = 1'b0,
    parameter int DEB_CYC = DEBOUNCE_CYC,
    parameter int STROBE_CYC = STROBE_MIN_CYC,
    parameter int CHANGE_CYC_P = CHANGE_CYC
) (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_arst_n,
    // link to controller and encoders
    cch_link_if.dev link,
    // core side status
    input wire logic [N_OUT-1:0] i_cam,
    input wire logic i_echo_mode,
    input wire logic i_run_mode,
    input wire logic i_online_mode,
    input wire logic i_prog_mode,
    input wire logic i_error,
    input wire logic i_speed_low,
    input wire logic i_unsaved,
    input wire logic [ENC_IDX_W-1:0] i_enc_idx,
    input wire logic i_dir_fwd,
    // core side results
    output logic [PNUM_W-1:0] o_prog_num,
    output logic o_prog_load,
    output logic o_cam_hold,
    output logic o_keypad_en,
    output logic [ENC_MAX-1:0] o_enc_pos,
    output logic o_enc_up,
    output logic o_enc_err
);
    // ************************************************************
    // elaboration checks and derived constants
    // ************************************************************
    initial begin
        if (N_OUT != 24 && N_OUT != 48) $error("N_OUT must be 24 or 48");
        if (N_PROG < 1 || N_PROG > PROG_MAX) $error("N_PROG out of range");
        if (ENC_BITS < 1 || ENC_BITS > ENC_MAX) $error("ENC_BITS out of range");
        if (N_ENC < 1 || N_ENC > SEL_W) $error("N_ENC out of range");
        if (DEB_CYC < 1 || STROBE_CYC < 1 || CHANGE_CYC_P < 1) $error("bad count");
        if (DEB_CYC >= (1 << CNT_W) || CHANGE_CYC_P >= (1 << CNT_W)) $error("count too big");
        if (STROBE_CYC >= (1 << CNT_W)) $error("count too big");
    end
    localparam int ECHO_LSB = N_OUT - ECHO_W;
    localparam int PW = (N_PROG >= PROG_MAX) ? PROG_W : $clog2(N_PROG + 1);
    localparam logic [PROG_W-1:0] PMASK = PROG_W'((1 << PW) - 1);
    localparam logic [ENC_PIN_W-1:0] EMASK = ENC_PIN_W'((1 << ENC_BITS) - 1);
    localparam logic [CNT_W-1:0] DEB_LAST = CNT_W'(DEB_CYC - 1);
    localparam logic [CNT_W-1:0] STB_LAST = CNT_W'(STROBE_CYC - 1);
    localparam logic [CNT_W-1:0] CHG_LAST = CNT_W'(CHANGE_CYC_P - 1);

    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed {
        logic [PROG_W:0] sel_s1;
        logic [PROG_W:0] sel_s2;
        logic [PROG_W:0] sel_db;
        logic [CNT_W-1:0] deb_cnt;
        logic stb_prev;
        logic [1:0] kp_s;
        cch_pstate_t st;
        logic [CNT_W-1:0] cnt;
        logic [PNUM_W-1:0] prog;
        logic load;
        logic [ENC_MAX-1:0] pos;
        logic enc_err;
        logic enc_up;
        logic lsb;
        logic [ENC_IDX_W-1:0] idx_prev;
        logic [N_OUT-1:0] cam;
        logic par;
        logic ready;
        logic store;
        logic rel;
        logic setup;
        logic dir;
        logic [SEL_W-1:0] sel_n;
    } cch_dev_st_t;

    cch_dev_st_t r_q;
    cch_dev_st_t r_d;
    logic stb_db;
    logic [PROG_W-1:0] masked;
    logic [PNUM_W-1:0] pnum;
    logic [ENC_PIN_W-1:0] raw;
    logic enc_ok;
    logic [ECHO_W-1:0] echo;

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        r_d = r_q;
        r_d.load = 1'b0;

        r_d.sel_s1 = {link.strobe, link.prog_sel};
        r_d.sel_s2 = r_q.sel_s1;
        if (r_q.sel_s2 == r_q.sel_db) begin
            r_d.deb_cnt = '0;
        end else if (r_q.deb_cnt == DEB_LAST) begin
            r_d.sel_db = r_q.sel_s2;
            r_d.deb_cnt = '0;
        end else begin
            r_d.deb_cnt = r_q.deb_cnt + 1'b1;
        end
        stb_db = r_q.sel_db[PROG_W];
        r_d.stb_prev = stb_db;

        // only configured bits count; all low means 32
        masked = r_q.sel_db[PROG_W-1:0] & PMASK;
        pnum = (masked == '0) ? PROG_ALL_LOW : {1'b0, masked};

        // rising strobe in run mode starts the hold check
        case (r_q.st)
            CCH_IDLE: begin
                if (stb_db && !r_q.stb_prev && i_run_mode) begin
                    r_d.st = CCH_QUAL;
                    r_d.cnt = '0;
                end
            end
            CCH_QUAL: begin
                if (!stb_db) begin
                    r_d.st = CCH_IDLE;
                end else if (r_q.cnt == STB_LAST) begin
                    r_d.st = CCH_IDLE;
                    // slow, run mode, no save pending
                    if (i_run_mode && i_speed_low && !i_unsaved
                        && pnum <= PNUM_W'(N_PROG)) begin
                        r_d.prog = pnum;
                        r_d.load = 1'b1;
                        r_d.st = CCH_CHANGE;
                        r_d.cnt = '0;
                    end
                end else begin
                    r_d.cnt = r_q.cnt + 1'b1;
                end
            end
            CCH_CHANGE: begin
                // cams suspended for the change time
                if (r_q.cnt == CHG_LAST) begin
                    r_d.st = CCH_IDLE;
                end else begin
                    r_d.cnt = r_q.cnt + 1'b1;
                end
            end
            default: r_d.st = CCH_IDLE;
        endcase

        r_d.kp_s = {r_q.kp_s[0], link.kp_enable};

        // bits above the encoder width are dropped
        raw = link.enc_data & EMASK;
        // odd parity over data and the bit just above it
        enc_ok = ^{raw, link.enc_data[ENC_BITS]};
        r_d.idx_prev = i_enc_idx;
        // new select gets one cycle to settle before use
        if (i_enc_idx == r_q.idx_prev) begin
            // mismatch flags error and keeps old value
            r_d.enc_err = !enc_ok;
            if (enc_ok) begin
                r_d.pos = raw[ENC_MAX-1:0];
                // three-encoder units echo encoder 1 only
                if (N_ENC != SEL_W || i_enc_idx == '0) begin
                    r_d.lsb = raw[0];
                end
            end
        end
        r_d.enc_up = link.enc_up;

        // with expander only the first line is used
        if (N_ENC == 1 || USE_EXPANDER) begin
            r_d.sel_n = SEL_FIRST_N;
        end else if (i_enc_idx < ENC_IDX_W'(N_ENC)) begin
            r_d.sel_n = ~(SEL_W'(1) << i_enc_idx);
        end else begin
            r_d.sel_n = SEL_NONE_N;
        end

        // echo replaces cam function of the group
        // group is the top eight outputs
        echo = ECHO_W'(r_q.prog);
        r_d.cam = i_cam;
        if (i_echo_mode) begin
            r_d.cam[ECHO_LSB +: ECHO_W] = echo;
        end
        // odd parity across echo and parity output
        r_d.par = i_echo_mode ? ~^echo : 1'b0;

        // error, programming and copy drop ready
        r_d.ready = !i_error && !i_prog_mode && r_d.st != CCH_CHANGE && !r_d.enc_err;
        r_d.store = i_unsaved;
        // release in run mode at low speed
        r_d.rel = i_run_mode && i_speed_low;
        r_d.setup = i_online_mode;
        r_d.dir = i_dir_fwd;
    end

    // ************************************************************
    // registers
    // ************************************************************
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            r_q <= '0;
            r_q.prog <= PROG_RESET;
            r_q.sel_n <= SEL_NONE_N;
        end else begin
            r_q <= r_d;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign link.cam_out = r_q.cam;
    assign link.program_parity_out = r_q.par;
    assign link.encoder_lsb_echo = r_q.lsb;
    assign link.ready = r_q.ready;
    assign link.store = r_q.store;
    assign link.release_ok = r_q.rel;
    assign link.setup = r_q.setup;
    assign link.enc_sel_n = r_q.sel_n;
    assign link.dir_fwd = r_q.dir;
    assign o_prog_num = r_q.prog;
    assign o_prog_load = r_q.load;
    assign o_cam_hold = (r_q.st == CCH_CHANGE);
    assign o_keypad_en = r_q.kp_s[1];
    assign o_enc_pos = r_q.pos;
    assign o_enc_up = r_q.enc_up;
    assign o_enc_err = r_q.enc_err;
endmodule // cch_dev

//--- logic/cch_ctl.sv
/*
 * machine controller end: ahb-lite slave with three word registers that
 * drive program select, timed strobe, keypad enable and encoder pins, and
 * report the cam controller status pins. zero wait states, always okay.
 */
`timescale 1ns/1ps
module cch_ctl
    import cch_pkg::*;
#(
    parameter int N_OUT = 24,
    parameter int HOLD_CYC = STROBE_HOLD_CYC
) (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_arst_n,
    // ahb-lite slave
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    output logic o_hreadyout,
    output logic [1:0] o_hresp,
    output logic [31:0] o_hrdata,
    // link
    cch_link_if.ctl link
);
    initial begin
        if (N_OUT != 24 && N_OUT != 48) $error("N_OUT must be 24 or 48");
        if (HOLD_CYC <= STROBE_MIN_CYC || HOLD_CYC >= (1 << CNT_W)) $error("bad hold");
    end
    localparam logic [CNT_W-1:0] HOLD_LAST = CNT_W'(HOLD_CYC - 1);

    typedef struct packed {
        logic wr_pend;
        logic [7:0] addr;
        logic [PROG_W-1:0] prog;
        logic strobe;
        logic [CNT_W-1:0] cnt;
        logic kp;
        logic up;
        logic [ENC_PIN_W-1:0] enc;
        logic [31:0] rdata;
    } cch_ctl_st_t;

    cch_ctl_st_t r_q;
    cch_ctl_st_t r_d;
    logic take;
    logic [31:0] ctrl_v;
    logic [31:0] stat_v;

    always_comb begin
        r_d = r_q;
        take = i_hsel && i_hready && (i_htrans == HTRANS_NONSEQ);
        ctrl_v = '0;
        ctrl_v[CTRL_PROG_LSB +: PROG_W] = r_q.prog;
        ctrl_v[CTRL_STROBE_BIT] = r_q.strobe;
        ctrl_v[CTRL_KEYPAD_BIT] = r_q.kp;
        ctrl_v[CTRL_UP_BIT] = r_q.up;
        stat_v = '0;
        stat_v[STAT_ECHO_LSB +: ECHO_W] = link.cam_out[N_OUT-ECHO_W +: ECHO_W];
        stat_v[STAT_READY_BIT] = link.ready;
        stat_v[STAT_STORE_BIT] = link.store;
        stat_v[STAT_RELEASE_BIT] = link.release_ok;
        stat_v[STAT_SETUP_BIT] = link.setup;
        stat_v[STAT_PARITY_BIT] = link.program_parity_out;
        stat_v[STAT_LSB_BIT] = link.encoder_lsb_echo;
        stat_v[STAT_DIR_BIT] = link.dir_fwd;
        stat_v[STAT_SEL_LSB +: SEL_W] = link.enc_sel_n;

        // strobe held past the device minimum, then dropped
        if (r_q.strobe) begin
            if (r_q.cnt == HOLD_LAST) begin
                r_d.strobe = 1'b0;
            end else begin
                r_d.cnt = r_q.cnt + 1'b1;
            end
        end

        // write data phase; a strobe request while one runs is ignored
        r_d.wr_pend = 1'b0;
        if (r_q.wr_pend) begin
            if (r_q.addr == REG_CTRL) begin
                r_d.prog = i_hwdata[CTRL_PROG_LSB +: PROG_W];
                r_d.kp = i_hwdata[CTRL_KEYPAD_BIT];
                r_d.up = i_hwdata[CTRL_UP_BIT];
                if (i_hwdata[CTRL_STROBE_BIT] && !r_q.strobe) begin
                    r_d.strobe = 1'b1;
                    r_d.cnt = '0;
                end
            end else if (r_q.addr == REG_ENC) begin
                r_d.enc = i_hwdata[ENC_PIN_W-1:0];
            end
        end

        // address phase: latch writes, prepare read data
        if (take) begin
            r_d.addr = i_haddr[7:0];
            r_d.wr_pend = i_hwrite;
            if (!i_hwrite) begin
                case (i_haddr[7:0])
                    REG_CTRL: r_d.rdata = ctrl_v;
                    REG_ENC: r_d.rdata = {{(32-ENC_PIN_W){1'b0}}, r_q.enc};
                    REG_STAT: r_d.rdata = stat_v;
                    default: r_d.rdata = '0;
                endcase
            end
        end
    end

    // everything resets low, so unused pins sit low
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            r_q <= '0;
        end else begin
            r_q <= r_d;
        end
    end

    assign o_hreadyout = 1'b1;
    assign o_hresp = HRESP_OKAY;
    assign o_hrdata = r_q.rdata;
    assign link.prog_sel = r_q.prog;
    assign link.strobe = r_q.strobe;
    assign link.kp_enable = r_q.kp;
    assign link.enc_data = r_q.enc;
    assign link.enc_up = r_q.up;
endmodule // cch_ctl

//--- verif/cch_link_properties.sv
/* link checker for the cam controller: pin relations on the shared link.
   assumes one clock and active-low reset, placed beside the link interface. */
`timescale 1ns/1ps
module cch_link_properties
    import cch_pkg::*;
#(
    parameter int N_OUT = 24,
    parameter int ENC_BITS = 15
) (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_arst_n,
    // controller side pins
    input wire logic [PROG_W-1:0] prog_sel,
    input wire logic strobe,
    input wire logic kp_enable,
    input wire logic [ENC_PIN_W-1:0] enc_data,
    // device side pins
    input wire logic [N_OUT-1:0] cam_out,
    input wire logic program_parity_out,
    input wire logic encoder_lsb_echo,
    input wire logic ready,
    input wire logic [SEL_W-1:0] enc_sel_n
);
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_arst_n);

    // ********************************************************
    // program echo
    // ********************************************************
    property p_echo_odd;
        program_parity_out |-> (^cam_out[N_OUT-1:N_OUT-ECHO_W]) == 1'b0;
    endproperty
    a_echo_odd: assert property (p_echo_odd)
        else $error("echo parity not odd");
    property p_echo_range;
        program_parity_out |-> cam_out[N_OUT-1:N_OUT-ECHO_W] <= 8'h20;
    endproperty
    a_echo_range: assert property (p_echo_range)
        else $error("echo group holds no program number");

    // ********************************************************
    // program select from the controller
    // ********************************************************
    property p_ctl_reset;
        $rose(i_arst_n) |-> !strobe && !kp_enable && prog_sel == 5'h00 && enc_data == 16'h0000;
    endproperty
    a_ctl_reset: assert property (p_ctl_reset)
        else $error("controller pins not low after reset");
    property p_strobe_hold;
        $rose(strobe) |=> strobe [*8];
    endproperty
    a_strobe_hold: assert property (p_strobe_hold)
        else $error("strobe dropped early");

    // ********************************************************
    // encoder port
    // ********************************************************
    property p_sel_single;
        $countones(~enc_sel_n) <= 1;
    endproperty
    a_sel_single: assert property (p_sel_single)
        else $error("more than one encoder selected");
    property p_sel_reset;
        $rose(i_arst_n) |-> enc_sel_n == SEL_NONE_N;
    endproperty
    a_sel_reset: assert property (p_sel_reset)
        else $error("encoder selected during reset");
    // three samples so a registered error path still has time to land
    property p_bad_parity;
        ((~^enc_data[ENC_BITS:0]) && $stable(enc_sel_n)) [*3] |-> !ready;
    endproperty
    a_bad_parity: assert property (p_bad_parity)
        else $error("ready high with bad encoder parity");
    property p_lsb_echo;
        (enc_sel_n == SEL_FIRST_N && $stable(enc_sel_n) && $stable(enc_data)
            && (^enc_data[ENC_BITS:0])) |-> encoder_lsb_echo == enc_data[0];
    endproperty
    a_lsb_echo: assert property (p_lsb_echo)
        else $error("lsb echo differs from encoder bit 0");
endmodule // cch_link_properties

//--- verif/cam_controller_io_handshake_test.sv
/* bench for the cam controller link: both ends joined, ahb master on the
   controller end, core levels driven on the device end. assumes 10 MHz. */
`timescale 1ns/1ps
module cam_controller_io_handshake_test;
    import cch_pkg::*;
    localparam int CHG = 30;
    int fails = 0;
    int n_tests = 0;
    logic i_mclk = 1'b0;
    logic i_arst_n = 1'b0;
    logic hsel = 1'b0, hwrite = 1'b0, hready;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
    logic [1:0] htrans = 2'h0, hresp;
    logic [2:0] hsize = 3'h2;
    logic [23:0] cam = 24'h0;
    logic echo = 1'b0, run = 1'b1, online = 1'b0, prog = 1'b0, err = 1'b0;
    logic spd = 1'b1, unsaved = 1'b0, dirf = 1'b0;
    logic [1:0] idx = 2'h0;
    logic [5:0] pnum;
    logic pload, chold, kpen, eup, eerr;
    logic [14:0] epos;

    always #50 i_mclk = ~i_mclk;

    cch_link_if link ();
    cch_dev #(.N_ENC(3), .ENC_BITS(12), .DEB_CYC(4), .STROBE_CYC(20), .CHANGE_CYC_P(CHG))
    i_cch_dev (
        .i_mclk(i_mclk), .i_arst_n(i_arst_n), .link(link), .i_cam(cam),
        .i_echo_mode(echo), .i_run_mode(run), .i_online_mode(online), .i_prog_mode(prog),
        .i_error(err), .i_speed_low(spd), .i_unsaved(unsaved), .i_enc_idx(idx),
        .i_dir_fwd(dirf), .o_prog_num(pnum), .o_prog_load(pload), .o_cam_hold(chold),
        .o_keypad_en(kpen), .o_enc_pos(epos), .o_enc_up(eup), .o_enc_err(eerr)
    );
    cch_ctl i_cch_ctl (
        .i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_hsel(hsel), .i_haddr(haddr),
        .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata),
        .i_hready(hready), .o_hreadyout(hready), .o_hresp(hresp), .o_hrdata(hrdata),
        .link(link)
    );
    cch_link_properties #(.ENC_BITS(12)) i_cch_link_properties (
        .i_mclk(i_mclk), .i_arst_n(i_arst_n), .prog_sel(link.prog_sel),
        .strobe(link.strobe), .kp_enable(link.kp_enable), .enc_data(link.enc_data),
        .cam_out(link.cam_out), .program_parity_out(link.program_parity_out),
        .encoder_lsb_echo(link.encoder_lsb_echo), .ready(link.ready),
        .enc_sel_n(link.enc_sel_n)
    );

    // ************************************************************
    // shared tasks
    // ************************************************************
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            $display("MISMATCH %s expected %h seen %h", s, e, g);
            fails++;
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic hwait();
        int n = 0;
        do begin
            @(posedge i_mclk);
            n++;
        end while (hready !== 1'b1 && n < 100);
        if (n >= 100) begin
            fails++;
            end_of_test();
        end
    endtask

    // one single word transfer; entered just after a rising edge
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd,
            output logic [31:0] rd);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= HTRANS_NONSEQ;
        hwait();
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= wd;
        hwait();
        rd = hrdata;
        chk("hresp", {30'h0, HRESP_OKAY}, {30'h0, hresp});
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        ahb(1'b1, a, d, x);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        ahb(1'b0, a, 32'h0, d);
    endtask

    // also clears a long strobe, which would otherwise block the next change
    task automatic do_reset();
        i_arst_n <= 1'b0;
        repeat (10) @(posedge i_mclk);
        i_arst_n <= 1'b1;
        @(posedge i_mclk);
        wr(REG_ENC, 32'h1000);
    endtask

    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic t_regs();
        logic [31:0] d;
        rd(8'h0c, d);
        chk("unmapped read", 32'h0, d);
        wr(REG_CTRL, 32'hc0);
        repeat (3) @(posedge i_mclk);
        chk("keypad on", 32'h1, {31'h0, kpen});
        chk("count up", 32'h1, {31'h0, eup});
        wr(REG_CTRL, 32'h0);
        repeat (3) @(posedge i_mclk);
        chk("keypad off", 32'h0, {31'h0, kpen});
        chk("count down", 32'h0, {31'h0, eup});
    endtask

    // inputs {prog, run, online, unsaved, error, speed, dir}
    task automatic t_status();
        logic [6:0] s [5] = '{7'h33, 7'h2a, 7'h26, 7'h20, 7'h42};
        logic [4:0] e [5] = '{5'h1d, 5'h07, 5'h04, 5'h01, 5'h00};
        logic [31:0] d;
        for (int k = 0; k < 5; k++) begin
            {prog, run, online, unsaved, err, spd, dirf} <= s[k];
            repeat (3) @(posedge i_mclk);
            rd(REG_STAT, d);
            chk("status", {27'h0, e[k]}, {27'h0, d[14], d[11:8]});
        end
        {prog, run, online, unsaved, err, spd, dirf} <= 7'h22;
    endtask

    // expected {position, error, ready, lsb echo, selects}
    task automatic t_enc();
        logic [15:0] v [5] = '{16'hf005, 16'h0006, 16'h1006, 16'h0007, 16'h1000};
        logic [1:0] ix [5] = '{2'h0, 2'h0, 2'h0, 2'h1, 2'h2};
        logic [20:0] ex [5] = '{{15'h5, 6'h1e}, {15'h5, 6'h2e}, {15'h6, 6'h16},
            {15'h7, 6'h15}, {15'h0, 6'h13}};
        for (int k = 0; k < 5; k++) begin
            idx <= ix[k];
            wr(REG_ENC, {16'h0, v[k]});
            repeat (3) @(posedge i_mclk);
            chk("encoder", {11'h0, ex[k]}, {11'h0, epos, eerr, link.ready,
                link.encoder_lsb_echo, link.enc_sel_n});
        end
        idx <= 2'h0;
    endtask

    task automatic t_echo(input logic [7:0] p);
        logic [31:0] d;
        cam <= 24'h5a5a5a;
        echo <= 1'b1;
        repeat (3) @(posedge i_mclk);
        rd(REG_STAT, d);
        chk("echo", {23'h0, ~^p, p}, {23'h0, d[12], d[7:0]});
        chk("low cams", 32'h5a5a, {16'h0, link.cam_out[15:0]});
        echo <= 1'b0;
        repeat (3) @(posedge i_mclk);
        rd(REG_STAT, d);
        chk("no echo", 32'h5a, {23'h0, d[12], d[7:0]});
    endtask

    // m is {run, speed low, unsaved}; only 3'b110 may be accepted
    task automatic t_change(input logic [4:0] p, input logic [2:0] m, input logic [5:0] x);
        int n = 0;
        do_reset();
        {run, spd, unsaved} <= m;
        wr(REG_CTRL, {26'h0, 1'b1, p});
        while (pload !== 1'b1 && n < 200) begin
            @(posedge i_mclk);
            n++;
        end
        chk("load", {31'h0, m == 3'b110}, {31'h0, pload});
        chk("program", {26'h0, x}, {26'h0, pnum});
        if (pload === 1'b1) begin
            chk("ready in change", 32'h0, {31'h0, link.ready});
            n = 0;
            while (chold === 1'b1 && n < 200) begin
                @(posedge i_mclk);
                n++;
            end
            chk("change length", CHG, n);
            repeat (2) @(posedge i_mclk);
            chk("ready after", 32'h1, {31'h0, link.ready});
        end
    endtask

    initial begin
        do_reset();
        t_regs();
        $display("test regs done");
        t_status();
        $display("test status done");
        t_enc();
        $display("test encoder done");
        t_echo(8'h01);
        $display("test echo done");
        t_change(5'h03, 3'b110, 6'h03);
        t_echo(8'h03);
        $display("test change done");
        t_change(5'h00, 3'b110, 6'h20);
        $display("test program 32 done");
        t_change(5'h05, 3'b100, 6'h01);
        t_change(5'h05, 3'b111, 6'h01);
        t_change(5'h05, 3'b010, 6'h01);
        $display("test refusals done");
        end_of_test();
    end
endmodule // cam_controller_io_handshake_test
